// File: logic/adccs_conv.sv
// Conversion sequencer: one channel or a scan of a group, fixed time per channel
`timescale 1ns/1ns
`default_nettype none
module adccs_conv
    import adccs_pkg::*;
#(
    parameter int CONV_CYCLES = ADCCS_CONV_CYCLES
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic       scan,
    input  wire logic [1:0] chan,
    input  wire logic [7:0] sample,
    output var  logic       busy,
    output var  logic       wr_en,
    output var  logic [1:0] wr_chan,
    output var  logic [7:0] wr_data,
    output var  logic       done
);
    adccs_state_t state_ff;
    logic [15:0]  cnt_ff;
    logic [1:0]   cur_ff;
    logic [1:0]   last_ff;
    logic         scan_ff;
    logic         ch_end;

    assign ch_end = (cnt_ff == 16'(CONV_CYCLES - 1));
    assign busy   = (state_ff != ADCCS_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ADCCS_IDLE;
            cnt_ff   <= 16'h0000;
            cur_ff   <= 2'h0;
            last_ff  <= 2'h0;
            scan_ff  <= 1'b0;
        end else begin
            unique case (state_ff)
                ADCCS_IDLE: begin
                    cnt_ff <= 16'h0000;
                    if (start) begin
                        scan_ff  <= scan;
                        cur_ff   <= scan ? 2'h0 : chan;
                        last_ff  <= chan;
                        state_ff <= ADCCS_CONV;
                    end
                end
                ADCCS_CONV: begin
                    cnt_ff <= ch_end ? 16'h0000 : cnt_ff + 16'h0001;
                    if (ch_end) begin
                        if (scan_ff && cur_ff != last_ff) begin
                            cur_ff <= cur_ff + 2'h1;
                        end else begin
                            state_ff <= ADCCS_DONE;
                        end
                    end
                end
                ADCCS_DONE: begin
                    state_ff <= ADCCS_IDLE;
                end
                default: begin
                    state_ff <= ADCCS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_en   <= 1'b0;
            wr_chan <= 2'h0;
            wr_data <= 8'h00;
        end else begin
            wr_en   <= (state_ff == ADCCS_CONV) && ch_end;
            wr_chan <= cur_ff;
            wr_data <= sample;
        end
    end

    // (R3) single done; (R4) scan done after last
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
        end else begin
            done <= (state_ff == ADCCS_CONV) && ch_end && !(scan_ff && cur_ff != last_ff);
        end
    end
endmodule : adccs_conv
`default_nettype wire

// File: logic/adccs_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module adccs_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output var  logic dout
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Output moves only once the last two stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout <= 1'b0;
        end else if (s2_ff == s3_ff) begin
            dout <= s3_ff;
        end
    end
endmodule : adccs_sync
`default_nettype wire

// File: logic/adccs_top.sv
// Converter control and status logic with APB register slave
// Functional notes
// (R1) Four result registers A-D at even addresses; address bit 0 ignored.
// (R2) End flag clears only on zero write after reading it as one.
// (R3) Single mode sets end flag when the selected channel finishes.
// (R4) Scan mode sets end flag only after all selected channels convert.
// (R5) Writing one to end flag bit 7 is ignored.
// (R6) Trigger enable bit 7 resets to 0; when 1, pin or software start.
// (R7) Trigger control bits 6..0 read as ones; writes ignored.
// (R8) Trigger disabled: pin edges ignored, only software starts conversion.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module adccs_top
    import adccs_pkg::*;
#(
    parameter int CONV_CYCLES = ADCCS_CONV_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        ext_conv_trigger_pin,
    input  wire logic [7:0]  analog_sample,
    output var  logic        conv_irq
);
    logic [7:0] result_ff [4];
    logic [7:0] ctrl_ff;
    logic       conv_end_flag_ff;
    logic       end_flag_seen_ff;
    logic       ext_trigger_enable_ff;
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_mask_ff;
    logic       trig_prev_ff;
    logic       trig_sync;
    logic       trig_rise;
    logic       busy;
    logic       wr_en;
    logic [1:0] wr_chan;
    logic [7:0] wr_data;
    logic       done;
    logic       sw_start;
    logic       hw_start;
    logic       start;
    logic       acc;
    logic       wr;
    logic       rd;
    logic [15:0] a_even;
    logic       hit;
    logic [31:0] nxt_rdata;
    logic        start_scan;
    logic [1:0]  start_chan;

    // Side effects fire once, at the access edge before pready; a second pass
    // at the pready edge would clear status again and lose a fresh event
    assign acc    = psel && penable && !pready;
    assign wr     = acc && pwrite;
    assign rd     = acc && !pwrite;
    // (R1) word index from byte address, index bit 0 dropped
    assign a_even = {paddr[17:3], 1'b0};

    adccs_sync u_trig_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (ext_conv_trigger_pin),
        .dout    (trig_sync)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_ff <= 1'b0;
        end else begin
            trig_prev_ff <= trig_sync;
        end
    end

    assign trig_rise = trig_sync && !trig_prev_ff;
    assign sw_start  = wr && (a_even == ADCCS_OFF_CTRL_STAT) && pwdata[ADCCS_CS_START];
    // (R6) (R8) pin start gated by enable
    assign hw_start  = trig_rise && ext_trigger_enable_ff;
    assign start     = (sw_start || hw_start) && !busy;
    // Mode bits written together with the start bit apply to that conversion
    assign start_scan = sw_start ? pwdata[ADCCS_CS_SCAN] : ctrl_ff[ADCCS_CS_SCAN];
    assign start_chan = sw_start ? pwdata[ADCCS_CS_CHAN_LSB +: 2] : ctrl_ff[ADCCS_CS_CHAN_LSB +: 2];

    adccs_conv #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_conv (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (start),
        .scan    (start_scan),
        .chan    (start_chan),
        .sample  (analog_sample),
        .busy    (busy),
        .wr_en   (wr_en),
        .wr_chan (wr_chan),
        .wr_data (wr_data),
        .done    (done)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                result_ff[i] <= 8'h00;
            end
        end else if (wr_en) begin
            result_ff[wr_chan] <= wr_data;
        end
    end

    // Mode and channel select; start bit is a pulse, not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= ADCCS_CS_RESET;
        end else if (wr && a_even == ADCCS_OFF_CTRL_STAT) begin
            ctrl_ff <= {3'h0, pwdata[4:0]};
        end
    end

    // (R2) clear needs prior read of one; (R3) (R4) set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_end_flag_ff <= 1'b0;
            end_flag_seen_ff <= 1'b0;
        end else begin
            if (rd && a_even == ADCCS_OFF_CTRL_STAT && conv_end_flag_ff) begin
                end_flag_seen_ff <= 1'b1;
            end
            if (done) begin
                conv_end_flag_ff <= 1'b1;
            // (R5) a written one never sets the flag
            end else if (wr && a_even == ADCCS_OFF_CTRL_STAT && !pwdata[ADCCS_CS_END_FLAG]
                         && end_flag_seen_ff) begin
                conv_end_flag_ff <= 1'b0;
                end_flag_seen_ff <= 1'b0;
            end
        end
    end

    // (R6) trigger enable resets to disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_trigger_enable_ff <= ADCCS_TRIG_RESET[ADCCS_TRIG_ENABLE];
        end else if (wr && a_even == ADCCS_OFF_TRIG_CTRL) begin
            ext_trigger_enable_ff <= pwdata[ADCCS_TRIG_ENABLE];
        end
    end

    // Sticky events, cleared by reading status; a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= ADCCS_IRQ_RESET;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == ADCCS_IRQ_END && done) || (i == ADCCS_IRQ_TRIG && hw_start)) begin
                    irq_stat_ff[i] <= 1'b1;
                end else if (rd && a_even == ADCCS_OFF_IRQ_STAT) begin
                    irq_stat_ff[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_ff <= ADCCS_IRQ_RESET;
        end else if (wr && a_even == ADCCS_OFF_IRQ_MASK) begin
            irq_mask_ff <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_irq <= 1'b0;
        end else begin
            conv_irq <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    always_comb begin
        hit       = 1'b1;
        nxt_rdata = 32'h0000_0000;
        unique case (a_even)
            // (R1) result registers
            ADCCS_OFF_RESULT_A:  nxt_rdata = {24'h0, result_ff[0]};
            ADCCS_OFF_RESULT_B:  nxt_rdata = {24'h0, result_ff[1]};
            ADCCS_OFF_RESULT_C:  nxt_rdata = {24'h0, result_ff[2]};
            ADCCS_OFF_RESULT_D:  nxt_rdata = {24'h0, result_ff[3]};
            ADCCS_OFF_CTRL_STAT: nxt_rdata = {24'h0, conv_end_flag_ff, busy, 1'b0, ctrl_ff[4:0]};
            // (R7) low bits read as ones
            ADCCS_OFF_TRIG_CTRL: nxt_rdata = {24'h0, ext_trigger_enable_ff, ADCCS_TRIG_ONES[6:0]};
            ADCCS_OFF_IRQ_STAT:  nxt_rdata = {30'h0, irq_stat_ff};
            ADCCS_OFF_IRQ_MASK:  nxt_rdata = {30'h0, irq_mask_ff};
            default:             hit = 1'b0;
        endcase
    end

    // Registered answer: one wait state, so prdata comes from a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            prdata  <= (psel && !pwrite) ? nxt_rdata : 32'h0000_0000;
            pslverr <= acc && !hit;
        end
    end
endmodule : adccs_top
`default_nettype wire

// File: pkg/adccs_pkg.sv
// Package: register map, field positions and timing for the converter control block
package adccs_pkg;
    localparam logic [15:0] ADCCS_OFF_RESULT_A  = 16'hffe0;
    localparam logic [15:0] ADCCS_OFF_RESULT_B  = 16'hffe2;
    localparam logic [15:0] ADCCS_OFF_RESULT_C  = 16'hffe4;
    localparam logic [15:0] ADCCS_OFF_RESULT_D  = 16'hffe6;
    localparam logic [15:0] ADCCS_OFF_CTRL_STAT = 16'hffe8;
    localparam logic [15:0] ADCCS_OFF_TRIG_CTRL = 16'hffec;
    localparam logic [15:0] ADCCS_OFF_IRQ_STAT  = 16'hfff0;
    localparam logic [15:0] ADCCS_OFF_IRQ_MASK  = 16'hfff4;

    // Control/status and trigger control fields
    localparam int ADCCS_CS_END_FLAG  = 7;
    localparam int ADCCS_CS_BUSY      = 6;
    localparam int ADCCS_CS_SCAN      = 4;
    localparam int ADCCS_CS_START     = 5;
    localparam int ADCCS_CS_CHAN_LSB  = 0;
    localparam int ADCCS_TRIG_ENABLE  = 7;

    localparam logic [7:0] ADCCS_CS_RESET   = 8'h00;
    localparam logic [7:0] ADCCS_TRIG_RESET = 8'h7f;
    localparam logic [7:0] ADCCS_TRIG_ONES  = 8'h7f;

    // Interrupt status bits
    localparam int ADCCS_IRQ_END  = 0;
    localparam int ADCCS_IRQ_TRIG = 1;
    localparam logic [1:0] ADCCS_IRQ_RESET = 2'h0;

    // Conversion time per channel
    localparam int ADCCS_CLK_MHZ     = 25;
    localparam int ADCCS_CONV_NS     = 4000;
    localparam int ADCCS_CONV_CYCLES = (ADCCS_CONV_NS * ADCCS_CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        ADCCS_IDLE = 3'b001,
        ADCCS_CONV = 3'b010,
        ADCCS_DONE = 3'b100
    } adccs_state_t;
endpackage : adccs_pkg

// File: verification/adccs_far_side.sv
// Trigger pin and sample source standing outside the block
`timescale 1ns/1ns
`default_nettype none
module adccs_far_side (
    input  wire logic       pclk,
    output var  logic [7:0] analog_sample,
    output var  logic       ext_conv_trigger_pin
);
    initial begin
        analog_sample = 8'h00;
        ext_conv_trigger_pin = 1'b0;
    end
    task automatic set_sample(input logic [7:0] v);
        @(posedge pclk);
        analog_sample <= v;
    endtask : set_sample
    // trigger pulse
    // Held long enough for the agreement filter to accept it
    task automatic pulse_pin();
        @(posedge pclk);
        ext_conv_trigger_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        ext_conv_trigger_pin <= 1'b0;
    endtask : pulse_pin
endmodule : adccs_far_side
`default_nettype wire

// File: verification/adccs_properties.sv
// Port-level checks of the converter control block
`timescale 1ns/1ns
`default_nettype none
module adccs_properties
    import adccs_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && $rose(penable);
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence
    a_ready_one_wait: assert property (s_access |-> s_answer) else $error("pready not after one wait state");
    a_ready_single: assert property (pready |=> !pready) else $error("pready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("pready outside access");
    a_err_no_data: assert property (pready && pslverr |-> prdata == 32'h0) else $error("error with data");
    a_unmapped_err: assert property (pready && paddr[17:5] == 13'h1fff |-> pslverr) else $error("no error");
    // Index bit 1 and bit 3 together fall into the two unmapped pairs
    a_mapped_no_err: assert property (pready && paddr[17:6] == 12'hffe && !(paddr[5] && paddr[3])
        |-> !pslverr) else $error("error on mapped register");
    a_trig_ones: assert property (pready && !pwrite && paddr[17:3] == ADCCS_OFF_TRIG_CTRL[15:1]
        |-> prdata[6:0] == 7'h7f) else $error("trigger control low bits not ones");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits set");
endmodule : adccs_properties
bind adccs_top adccs_properties chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr);
`default_nettype wire

// File: verification/tb_top.sv
// Register-level testbench of the converter control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import adccs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_irq, trig_pin, slv;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  sample;
    int          errors, compares, cycles;

    adccs_top #(.CONV_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_conv_trigger_pin(trig_pin), .analog_sample(sample), .conv_irq(conv_irq));
    adccs_far_side far (.pclk(pclk), .analog_sample(sample), .ext_conv_trigger_pin(trig_pin));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic wrap_up();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Called just after a rising edge; one idle edge after release
    // Takes a register index; no cycle limit, a hang ends at the bench timeout
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(nm, rd, exp);
    endtask : rdchk

    task automatic wait_irq();
        int n;
        n = 0;
        while (conv_irq !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk("conv_irq", {31'h0, conv_irq}, 32'h1);
    endtask : wait_irq

    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 18'h00000;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("trig reset", ADCCS_OFF_TRIG_CTRL, 32'h7f);
        apb(1'b1, ADCCS_OFF_TRIG_CTRL, 8'h00);
        rdchk("trig ones", ADCCS_OFF_TRIG_CTRL, 32'h7f);
        apb(1'b1, ADCCS_OFF_IRQ_MASK, 8'h01);
        apb(1'b1, ADCCS_OFF_CTRL_STAT, 8'h80);
        far.pulse_pin();
        repeat (20) @(posedge pclk);
        rdchk("no set no pin", ADCCS_OFF_CTRL_STAT, 32'h00);
        rdchk("no pin irq", ADCCS_OFF_IRQ_STAT, 32'h00);
        far.set_sample(8'h5a);
        apb(1'b1, ADCCS_OFF_CTRL_STAT, 8'h22);
        wait_irq();
        rdchk("result c odd", ADCCS_OFF_RESULT_C | 16'h1, 32'h5a);
        apb(1'b1, ADCCS_OFF_CTRL_STAT, 8'h00);
        rdchk("flag kept", ADCCS_OFF_CTRL_STAT, 32'h80);
        apb(1'b1, ADCCS_OFF_CTRL_STAT, 8'h00);
        rdchk("flag cleared", ADCCS_OFF_CTRL_STAT, 32'h00);
        rdchk("irq status", ADCCS_OFF_IRQ_STAT, 32'h01);
        chk("irq low", {31'h0, conv_irq}, 32'h0);
        far.set_sample(8'h3c);
        apb(1'b1, ADCCS_OFF_CTRL_STAT, 8'h33);
        // Late enough that a flag raised after the first channel would show
        repeat (4) @(posedge pclk);
        rdchk("scan busy", ADCCS_OFF_CTRL_STAT, 32'h53);
        wait_irq();
        rdchk("scan done", ADCCS_OFF_CTRL_STAT, 32'h93);
        for (int i = 0; i < 4; i++) begin
            rdchk("scan result", ADCCS_OFF_RESULT_A + 16'(2 * i), 32'h3c);
        end
        apb(1'b1, ADCCS_OFF_RESULT_A, 8'hff);
        rdchk("result ro", ADCCS_OFF_RESULT_A, 32'h3c);
        apb(1'b1, ADCCS_OFF_CTRL_STAT, 8'h00);
        rdchk("irq clear", ADCCS_OFF_IRQ_STAT, 32'h01);
        apb(1'b1, ADCCS_OFF_TRIG_CTRL, 8'h80);
        rdchk("trig on", ADCCS_OFF_TRIG_CTRL, 32'hff);
        far.set_sample(8'h99);
        far.pulse_pin();
        wait_irq();
        rdchk("pin result", ADCCS_OFF_RESULT_A, 32'h99);
        rdchk("pin irq", ADCCS_OFF_IRQ_STAT, 32'h03);
        apb(1'b0, 16'hfff8, 8'h00);
        chk("slverr", {31'h0, slv}, 32'h1);
        chk("err data", rd, 32'h0);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
